// [bcc_pkg.sv]
package bcc_pkg;

	// Byte addresses of the register words.
	localparam logic [7:0] INSTR_OFS = 8'h00;
	localparam logic [7:0] OPND_OFS  = 8'h04;
	localparam logic [7:0] PC_OFS    = 8'h08;
	localparam logic [7:0] CTX_OFS   = 8'h0c;
	localparam logic [7:0] STAT_OFS  = 8'h10;
	localparam logic [7:0] STACK_OFS = 8'h14;

	localparam int              STACK_DEPTH = 12;
	localparam logic [3:0]      STACK_TOP   = 4'hc;
	localparam logic [15:0]     PC_RESET    = 16'h0000;
	localparam logic [15:0]     SHORT_LEN   = 16'h0001;
	localparam logic [15:0]     LONG_LEN    = 16'h0002;
	localparam logic [7:0]      LSB_CLEAR   = 8'hfe;
	localparam logic [7:0]      ALL_ONES    = 8'hff;

	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_COND_REL  = 3'b001,
		OP_COND_LONG = 3'b010,
		OP_ROT_MASK  = 3'b011,
		OP_CALL_REL  = 3'b100,
		OP_CALL_LONG = 3'b101,
		OP_CALL_COND = 3'b110,
		OP_JUMP_REL  = 3'b111
	} bcc_op_e;

	// Flag selector codes.
	localparam logic [2:0] SEL_ZERO = 3'b000;
	localparam logic [2:0] SEL_CARRY = 3'b001;
	localparam logic [2:0] SEL_OVFL = 3'b010;
	localparam logic [2:0] SEL_NEG  = 3'b011;
	localparam logic [2:0] SEL_RXB  = 3'b100;
	localparam logic [2:0] SEL_RXF  = 3'b101;
	localparam logic [2:0] SEL_RXW  = 3'b110;
	localparam logic [2:0] SEL_TXQ  = 3'b111;

	typedef struct packed {
		logic [7:0] disp;
		logic [4:0] rsv_a;
		logic [2:0] mask_cnt;
		logic       rsv_b;
		logic [2:0] rot_cnt;
		logic       rsv_c;
		logic [2:0] bit_pos;
		logic       want;
		logic [2:0] flag_sel;
		logic       rsv_d;
		bcc_op_e    op;
	} bcc_instr_s;

	// Context: bank select, global_irq_enable, link_status_reg and alu_flag_reg bits.
	typedef struct packed {
		logic [1:0] bank;
		logic       global_irq_enable;
		logic       tx_queue_full;
		logic       rx_word_ready;
		logic       rx_fault_flag;
		logic       rx_busy_flag;
		logic       neg;
		logic       ovfl;
		logic       carry;
		logic       zero;
	} bcc_ctx_s;

	typedef struct packed {
		logic [15:0] ret_pc;
		bcc_ctx_s    ctx;
	} bcc_frame_s;

	localparam int FRAME_W = $bits(bcc_frame_s);
	localparam int CTX_W   = $bits(bcc_ctx_s);

	typedef struct packed {
		logic [7:0] opnd;
		logic [15:0] target;
	} bcc_opnd_s;

	localparam int OPND_W = $bits(bcc_opnd_s);

	// Register field positions.
	localparam int         PC_W        = 16;
	localparam int         OVF_CLR_BIT = 5;
	localparam logic [3:0] STACK_EMPTY = 4'h0;

endpackage

// [bcc_branch_ctrl.sv]
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module bcc_branch_ctrl
	import bcc_pkg::*;
(
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR,
	// Execution strobe, one cycle after each executed instruction, and the branch result, held until the next.
	output logic             EXEC_DONE,
	output logic             BRANCH_TAKEN
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic pick_flag(input bcc_ctx_s c, input logic [2:0] sel);
		logic f;
		f = 1'b0;
		unique case (sel)
			SEL_ZERO:  f = c.zero;
			SEL_CARRY: f = c.carry;
			SEL_OVFL:  f = c.ovfl;
			SEL_NEG:   f = c.neg;
			SEL_RXB:   f = c.rx_busy_flag;
			SEL_RXF:   f = c.rx_fault_flag;
			SEL_RXW:   f = c.rx_word_ready;
			SEL_TXQ:   f = c.tx_queue_full;
		endcase
		return f;
	endfunction

	function automatic logic [15:0] add_rel(input logic [15:0] pc, input logic [7:0] d);
		return pc + {{8{d[7]}}, d};
	endfunction

	function automatic logic [7:0] rot_right(input logic [7:0] v, input logic [2:0] n);
		logic [15:0] w;
		w = {v, v} >> n;
		return w[7:0];
	endfunction

	function automatic logic is_addr(input logic [7:0] a);
		return (a == INSTR_OFS) || (a == OPND_OFS) || (a == PC_OFS) ||
			(a == CTX_OFS) || (a == STAT_OFS) || (a == STACK_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State.

	bcc_opnd_s   opnd_q;
	logic [15:0] pc_q;
	bcc_ctx_s    ctx_q;
	bcc_frame_s  stack_q [STACK_DEPTH];
	logic [3:0]  sp_q;
	logic        ovf_q;
	logic        taken_q;
	logic        ready_q;
	logic [31:0] rdata_q;
	logic        err_q;
	logic        done_q;

	logic        wr_en;
	logic        rd_en;
	logic        exec;
	bcc_instr_s  ins;

	// Two-cycle access: the first access cycle loads read data, the second completes.
	assign wr_en = PSEL && PENABLE && ready_q && PWRITE;
	assign rd_en = PSEL && PENABLE && !ready_q;
	assign exec  = wr_en && (PADDR == INSTR_OFS);
	assign ins   = bcc_instr_s'(PWDATA);

	////////////////////////////////////////////////////////////////////////////
	// Register write strobes. Each lands only at the edge that completes the
	// access, so a stalled or abandoned transfer never disturbs state.

	logic        wr_pc;
	logic        wr_opnd;
	logic        wr_ctx;
	logic        wr_stat;
	logic        wr_stack;
	logic        stk_full;
	logic        stk_empty;

	assign wr_pc     = wr_en && (PADDR == PC_OFS);
	assign wr_opnd   = wr_en && (PADDR == OPND_OFS);
	assign wr_ctx    = wr_en && (PADDR == CTX_OFS);
	assign wr_stat   = wr_en && (PADDR == STAT_OFS);
	assign wr_stack  = wr_en && (PADDR == STACK_OFS);
	assign stk_full  = (sp_q == STACK_TOP);
	assign stk_empty = (sp_q == STACK_EMPTY);

	////////////////////////////////////////////////////////////////////////////
	// Instruction evaluation. Every opcode is worked out each cycle from the
	// write data; only the exec strobe lets the result reach any register.

	logic        take;
	logic        push;
	logic [15:0] pc_seq;
	logic [15:0] pc_d;
	logic [7:0]  rot_v;
	logic [7:0]  rm_disp;
	logic        flag_hit;
	logic        bit_hit;

	always_comb begin
		flag_hit = (pick_flag(ctx_q, ins.flag_sel) == ins.want);
		bit_hit  = (opnd_q.opnd[ins.bit_pos] == ins.want);
		// The source register copy is rotated here; opnd_q is never written back.
		rot_v    = rot_right(opnd_q.opnd, ins.rot_cnt);
		rm_disp  = rot_v & (ALL_ONES >> ins.mask_cnt) & LSB_CLEAR;
		take     = 1'b0;
		push     = 1'b0;
		pc_seq   = pc_q + SHORT_LEN;
		pc_d     = pc_seq;
		unique case (ins.op)
			OP_NONE: begin
				pc_d = pc_seq;
			end
			OP_COND_REL: begin
				take = flag_hit;
				if (flag_hit) begin
					pc_d = add_rel(pc_seq, ins.disp);
				end
			end
			OP_JUMP_REL: begin
				take = 1'b1;
				pc_d = add_rel(pc_seq, ins.disp);
			end
			OP_COND_LONG: begin
				pc_seq = pc_q + LONG_LEN;
				take   = bit_hit;
				pc_d   = bit_hit ? opnd_q.target : pc_seq;
			end
			OP_ROT_MASK: begin
				take = 1'b1;
				pc_d = add_rel(pc_seq, rm_disp);
			end
			OP_CALL_REL: begin
				take = 1'b1;
				push = 1'b1;
				pc_d = add_rel(pc_seq, ins.disp);
			end
			OP_CALL_LONG: begin
				pc_seq = pc_q + LONG_LEN;
				take   = 1'b1;
				push   = 1'b1;
				pc_d   = opnd_q.target;
			end
			OP_CALL_COND: begin
				pc_seq = pc_q + LONG_LEN;
				take   = bit_hit;
				push   = bit_hit;
				pc_d   = bit_hit ? opnd_q.target : pc_seq;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Program counter.

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pc_q <= PC_RESET;
		end else if (exec) begin
			pc_q <= pc_d;
		end else if (wr_pc) begin
			pc_q <= PWDATA[PC_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Operand and context. Branches never write the context.

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			opnd_q <= '0;
		end else if (wr_opnd) begin
			opnd_q <= bcc_opnd_s'(PWDATA[OPND_W-1:0]);
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctx_q <= '0;
		end else if (wr_ctx) begin
			ctx_q <= bcc_ctx_s'(PWDATA[CTX_W-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address stack. A write to the stack word discards the top entry, which is
	// how the return and interrupt logic outside releases a level.

	// No reset here: an entry is only ever read below the pointer, which reset clears.
	always_ff @(posedge CLK) begin
		if (exec && push && !stk_full) begin
			stack_q[sp_q] <= '{ret_pc: pc_seq, ctx: ctx_q};
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sp_q <= '0;
		end else if (exec && push) begin
			if (!stk_full) begin
				sp_q <= sp_q + 4'h1;
			end
		end else if (wr_stack && !stk_empty) begin
			sp_q <= sp_q - 4'h1;
		end
	end

	// A thirteenth level is dropped and flagged; the push wins over a clear.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ovf_q <= 1'b0;
		end else if (exec && push && stk_full) begin
			ovf_q <= 1'b1;
		end else if (wr_stat && PWDATA[OVF_CLR_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Execution status.

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_q  <= 1'b0;
			taken_q <= 1'b0;
		end else begin
			done_q <= exec;
			if (exec) begin
				taken_q <= take;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB response. Read data is captured in the first access cycle; nothing
	// can write a register before the access completes, so the word is still
	// current when PREADY rises.

	logic [31:0] rd_mux;
	bcc_frame_s  top_frame;

	always_comb begin
		top_frame = stk_empty ? '0 : stack_q[sp_q - 4'h1];
		rd_mux    = '0;
		unique case (PADDR)
			OPND_OFS:  rd_mux = {8'h00, opnd_q};
			PC_OFS:    rd_mux = {16'h0000, pc_q};
			CTX_OFS:   rd_mux = {{(32-CTX_W){1'b0}}, ctx_q};
			STAT_OFS:  rd_mux = {26'h0, ovf_q, taken_q, sp_q};
			STACK_OFS: rd_mux = {{(32-FRAME_W){1'b0}}, top_frame};
			default:   rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ready_q <= 1'b0;
			rdata_q <= '0;
			err_q   <= 1'b0;
		end else if (rd_en) begin
			ready_q <= 1'b1;
			rdata_q <= PWRITE ? 32'h00000000 : rd_mux;
			err_q   <= !is_addr(PADDR);
		end else begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end
	end

	assign PREADY       = ready_q;
	assign PRDATA       = rdata_q;
	assign PSLVERR      = err_q;
	assign EXEC_DONE    = done_q;
	assign BRANCH_TAKEN = taken_q;

endmodule

// [bcc_branch_ctrl_assertions.sv]
`timescale 1ns/1ps
module bcc_branch_ctrl_chk
	import bcc_pkg::*;
(
	// Clock and reset.
	input wire logic        CLK,
	input wire logic        RST_N,
	// APB.
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic [31:0] PRDATA,
	input wire logic        PSLVERR,
	// Execution.
	input wire logic        EXEC_DONE,
	input wire logic        BRANCH_TAKEN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	ready_step_a: assert property (PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY)
		else $error("pready not in second access cycle");
	ready_once_a: assert property (PREADY |=> !PREADY) else $error("pready too long");
	ready_phase_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray pready");
	err_map_a: assert property (PREADY |-> PSLVERR == (PADDR > STACK_OFS || PADDR[1:0] != 2'h0))
		else $error("pslverr wrong");
	exec_pulse_a: assert property (PREADY && PWRITE && PADDR == INSTR_OFS |=> EXEC_DONE ##1 !EXEC_DONE)
		else $error("exec pulse wrong");
	exec_cause_a: assert property (EXEC_DONE |-> $past(PREADY && PWRITE && PADDR == INSTR_OFS))
		else $error("exec without write");
	taken_hold_a: assert property (!EXEC_DONE |-> $stable(BRANCH_TAKEN))
		else $error("taken changed without execution");
	depth_max_a: assert property (PREADY && !PWRITE && PADDR == STAT_OFS |->
		PRDATA[3:0] <= STACK_TOP && PRDATA[31:6] == 26'h0) else $error("stack depth out of range");
	wr_data_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h0) else $error("write data seen");
	cover property (EXEC_DONE && BRANCH_TAKEN);
	cover property (EXEC_DONE && !BRANCH_TAKEN);
	cover property (PREADY && PSLVERR);
	cover property (PREADY && PADDR == STAT_OFS && PRDATA[5]);
endmodule

bind bcc_branch_ctrl bcc_branch_ctrl_chk i_bcc_branch_ctrl_chk (.CLK, .RST_N, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .EXEC_DONE, .BRANCH_TAKEN);

// [tb_bcc_branch_ctrl.sv]
`timescale 1ns/1ps
module tb_bcc_branch_ctrl;
	import bcc_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, exec_done, taken, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          n_mismatch, checks;

	bcc_branch_ctrl i_bcc_branch_ctrl (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .EXEC_DONE(exec_done), .BRANCH_TAKEN(taken));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task give_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// The slave answers when it likes, so the access phase waits on pready.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			n_mismatch++;
	endtask

	function logic [31:0] mk(logic [2:0] op, logic [2:0] sel, logic w, logic [2:0] pos,
		logic [2:0] rot, logic [2:0] m, logic [7:0] dsp);
		return {dsp, 5'h0, m, 1'b0, rot, 1'b0, pos, w, sel, 1'b0, op};
	endfunction

	task ex(input logic [31:0] ins, input logic [15:0] pc0, input logic [15:0] pce, input logic tk);
		apb(1'b1, PC_OFS, {16'h0, pc0});
		apb(1'b1, INSTR_OFS, ins);
		#1;
		chk("exec_done", 32'h1, {31'h0, exec_done});
		chk("taken", {31'h0, tk}, {31'h0, taken});
		apb(1'b0, PC_OFS, 32'h0);
		chk("pc", {16'h0, pce}, rd);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		apb(1'b0, PC_OFS, 32'h0);
		chk("pc", 32'h0, rd);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("stat", 32'h0, rd);
		apb(1'b0, 8'h18, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		apb(1'b1, 8'h1c, 32'h1);
		chk("pslverr", 32'h1, {31'h0, er});
	endtask

	// Other flags are set opposite to the selected one to catch a wrong select.
	task t_flags;
		logic [7:0]  c, d;
		logic        hit;
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 4; k++) begin
				c = k[1] ? 8'h01 << s : 8'hff ^ (8'h01 << s);
				hit = (k[1] == k[0]);
				d = k[0] ? 8'h7f : 8'h80;
				apb(1'b1, CTX_OFS, {24'h0, c});
				ex(mk(OP_COND_REL, s[2:0], k[0], 3'h0, 3'h0, 3'h0, d), 16'h0100,
					hit ? 16'h0101 + {{8{d[7]}}, d} : 16'h0101, hit);
				apb(1'b0, CTX_OFS, 32'h0);
				chk("ctx", {24'h0, c}, rd);
			end
	endtask

	task t_long;
		logic hit;
		apb(1'b1, OPND_OFS, 32'h00a5_beef);
		for (int p = 0; p < 8; p++) begin
			hit = (8'ha5 >> p) & 8'h01 ? p[0] : !p[0];
			ex(mk(OP_COND_LONG, 3'h0, p[0], p[2:0], 3'h0, 3'h0, 8'h0), 16'h0300,
				hit ? 16'hbeef : 16'h0302, hit);
		end
	endtask

	task t_rot;
		logic [3:0][7:0] v;
		logic [3:0][2:0] r;
		logic [3:0][2:0] m;
		logic [7:0]      d;
		v = {8'h5a, 8'h12, 8'hff, 8'h81};
		r = {3'h5, 3'h1, 3'h3, 3'h0};
		m = {3'h2, 3'h4, 3'h1, 3'h0};
		for (int i = 0; i < 4; i++) begin
			d = ((v[i] >> r[i]) | (v[i] << (4'h8 - r[i]))) & (8'hff >> m[i]) & 8'hfe;
			apb(1'b1, OPND_OFS, {8'h0, v[i], 16'h0});
			ex(mk(OP_ROT_MASK, 3'h0, 1'b0, 3'h0, r[i], m[i], 8'h0), 16'h0400,
				16'h0401 + {{8{d[7]}}, d}, 1'b1);
			apb(1'b0, OPND_OFS, 32'h0);
			chk("opnd", {8'h0, v[i], 16'h0}, rd);
		end
	endtask

	task t_call;
		apb(1'b1, CTX_OFS, 32'h5a5);
		ex(mk(OP_CALL_REL, 3'h0, 1'b0, 3'h0, 3'h0, 3'h0, 8'h7f), 16'h0200, 16'h0280, 1'b1);
		apb(1'b0, STACK_OFS, 32'h0);
		chk("stack", {5'h0, 16'h0201, 11'h5a5}, rd);
		apb(1'b1, OPND_OFS, 32'h0012_3456);
		for (int i = 0; i < 12; i++)
			ex(mk(OP_CALL_LONG, 3'h0, 1'b0, 3'h0, 3'h0, 3'h0, 8'h0), 16'h0280, 16'h3456, 1'b1);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("stat", 32'h3c, rd);
		apb(1'b1, STACK_OFS, 32'h0);
		apb(1'b0, STACK_OFS, 32'h0);
		chk("stack", {5'h0, 16'h0282, 11'h5a5}, rd);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("depth", 32'hb, {28'h0, rd[3:0]});
		apb(1'b0, CTX_OFS, 32'h0);
		chk("ctx", 32'h5a5, rd);
	endtask

	// Runs after t_call, which leaves eleven levels in use and overflow set.
	task t_misc;
		apb(1'b1, OPND_OFS, 32'h0003_1234);
		ex(mk(OP_CALL_COND, 3'h0, 1'b1, 3'h1, 3'h0, 3'h0, 8'h0), 16'h0600, 16'h1234, 1'b1);
		apb(1'b0, STACK_OFS, 32'h0);
		chk("stack", {5'h0, 16'h0602, 11'h5a5}, rd);
		ex(mk(OP_CALL_COND, 3'h0, 1'b1, 3'h2, 3'h0, 3'h0, 8'h0), 16'h0600, 16'h0602, 1'b0);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("stat", 32'h2c, rd);
		apb(1'b1, STAT_OFS, 32'h20);
		apb(1'b0, STAT_OFS, 32'h0);
		chk("stat", 32'h0c, rd);
		ex(mk(OP_NONE, 3'h0, 1'b0, 3'h0, 3'h0, 3'h0, 8'h7f), 16'h0500, 16'h0501, 1'b0);
		ex(mk(OP_JUMP_REL, 3'h0, 1'b0, 3'h0, 3'h0, 3'h0, 8'h80), 16'h0500, 16'h0481, 1'b1);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_flags();
		t_long();
		t_rot();
		t_call();
		t_misc();
		give_verdict();
	end
endmodule
